// ===== bench/vpt_host.sv
// Processor model that issues virtual addresses to the translator.
`timescale 1ns/100ps
module vpt_host (
  input  wire logic   clk,
  output logic        addr_strobe,
  output logic [31:0] virt_addr,
  output logic        user_mode,
  output logic        write_acc
);
  // Idle bus at time zero.
  initial begin
    addr_strobe = 1'b0;
    virt_addr = 32'h0;
    user_mode = 1'b0;
    write_acc = 1'b0;
  end
  // A request stands over one sampling edge; the released bus then carries the inverse, not a stale copy.
  task automatic access(input logic [31:0] a, input logic u, input logic w);
    @(posedge clk);
    #1 addr_strobe = 1'b1;
    virt_addr = a;
    user_mode = u;
    write_acc = w;
    @(posedge clk);
    #1 addr_strobe = 1'b0;
    virt_addr = ~a;
  endtask : access
endmodule : vpt_host

// ===== bench/vpt_translator_chk.sv
// Port checker for the virtual page translator.
`timescale 1ns/100ps
module vpt_translator_chk (
  input wire logic        clock_phase_one,
  input wire logic        rst,
  input wire logic        chip_reset_input,
  input wire logic        addr_strobe,
  input wire logic [31:0] virt_addr,
  input wire logic [31:0] phys_addr,
  input wire logic        phys_addr_valid_strobe_n,
  input wire logic        reset_abort_output_n,
  input wire logic [31:0] fault_addr
);
  default clocking cb @(posedge clock_phase_one); endclocking
  default disable iff (rst);
  // An abort is a fall of the output outside reset; a longer low level would read as a reset.
  sequence abort_start;
    !reset_abort_output_n && $past(reset_abort_output_n) && !$past(chip_reset_input) && !chip_reset_input;
  endsequence
  // A taken request gets a pass or an abort on the next edge, never both and never neither.
  a_one_answer: assert property (
    addr_strobe && reset_abort_output_n && !chip_reset_input |=> phys_addr_valid_strobe_n != reset_abort_output_n)
    else $error("request not answered once");
  a_offset_kept: assert property (
    !phys_addr_valid_strobe_n |-> phys_addr[11:0] == $past(virt_addr[11:0])) else $error("offset altered");
  a_abort_short: assert property (abort_start |=> reset_abort_output_n) else $error("abort too long");
  a_fault_capture: assert property (
    abort_start |-> fault_addr == $past(virt_addr)) else $error("fault address not captured");
  a_reset_output: assert property (chip_reset_input |=> !reset_abort_output_n) else $error("reset not shown");
  a_quiet_reset: assert property (
    chip_reset_input ##1 chip_reset_input |=> phys_addr_valid_strobe_n) else $error("strobe in reset");
  a_dead_after_abort: assert property (
    !reset_abort_output_n |-> phys_addr_valid_strobe_n [*2]) else $error("strobe beside abort");
  a_fault_kept: assert property (
    chip_reset_input && $past(chip_reset_input) |=> $stable(fault_addr)) else $error("reset moved fault address");
  // Main scenarios seen.
  c_pass: cover property (!phys_addr_valid_strobe_n);
  c_abort: cover property (abort_start);
  c_reset: cover property (chip_reset_input ##1 !chip_reset_input);
endmodule : vpt_translator_chk
bind vpt_translator vpt_translator_chk i_vpt_translator_chk (
  .clock_phase_one(clock_phase_one), .rst(rst), .chip_reset_input(chip_reset_input), .addr_strobe(addr_strobe),
  .virt_addr(virt_addr), .phys_addr(phys_addr), .phys_addr_valid_strobe_n(phys_addr_valid_strobe_n),
  .reset_abort_output_n(reset_abort_output_n), .fault_addr(fault_addr)
);

// ===== bench/vpt_translator_tb.sv
// Self-checking bench for the virtual page translator with a page model.
`timescale 1ns/100ps
module vpt_translator_tb;
  logic                clk;
  logic                rst         = 1'b1;
  logic                chip_rst    = 1'b1; // Chip reset stands from power-up.
  localparam int       POWERUP_CYCLES = 5000; // 50 microseconds of 10 ns cycles.
  logic                xlat        = 1'b0;
  logic [3:0]          wr_sel      = 4'h0;
  logic [7:0]          ctrl_wdata  = 8'h00;
  logic [2:0]          entry_idx   = 3'h0;
  logic [31:0]         watch_lo    = 32'h0, watch_hi = 32'h0;
  vpt_pkg::vpt_entry_s entry_wdata = '0;
  logic [31:0]         va, pa, fa, r;
  logic [7:0]          ctrl, stat;
  logic                strobe, usr, wr, pav_n, ra_n, dh;
  int                  bad_count, checked, seed, k, i, hit;
  int                  m_vp[8], m_fr[8];
  vpt_host i_vpt_host (.clk(clk), .addr_strobe(strobe), .virt_addr(va), .user_mode(usr), .write_acc(wr));
  vpt_translator i_vpt_translator (
    .clock_phase_one(clk), .clock_phase_two(~clk), .rst(rst), .chip_reset_input(chip_rst),
    .addr_strobe(strobe), .virt_addr(va), .user_mode(usr), .write_acc(wr), .ctrl_wr(wr_sel[0]),
    .ctrl_wdata(ctrl_wdata), .entry_wr(wr_sel[1]), .entry_idx(entry_idx), .entry_wdata(entry_wdata),
    .watch_wr(wr_sel[2]), .watch_lo(watch_lo), .watch_hi(watch_hi), .status_clr(wr_sel[3]),
    .phys_addr(pa), .phys_addr_valid_strobe_n(pav_n), .reset_abort_output_n(ra_n), .fault_addr(fa),
    .translation_control_reg(ctrl), .translation_status_reg(stat), .debug_hit(dh)
  );
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // One-cycle write strobe: 0 control, 1 entry, 2 watch, 3 status clear; data is set beforehand.
  task automatic pulse(input int sel);
    @(posedge clk);
    #1 wr_sel = 4'h1 << sel;
    @(posedge clk);
    #1 wr_sel = 4'h0;
  endtask : pulse
  // The model predicts pass or abort; entry index bit 0 grants user access, bit 1 grants writes.
  task automatic probe(input logic [31:0] a, input logic u, input logic w);
    logic ok;
    hit = -1;
    for (k = 0; k < 8; k++)
      if (m_vp[k] == a[31:12])
        hit = k;
    ok = !xlat || (hit >= 0 && (!u || hit[0]) && (!w || hit[1]));
    i_vpt_host.access(a, u, w);
    check(pav_n, !ok);
    check(ra_n, ok);
    if (ok)
      check(pa, xlat ? {m_fr[hit][19:0], a[11:0]} : a);
    else begin
      check(fa, a);
      check(stat[vpt_pkg::STAT_FAULT], 1'b1);
      check(stat[vpt_pkg::STAT_PROT], hit >= 0);
    end
  endtask : probe
  // Sets a watch mode, clears status, makes one read and looks for the watch flag.
  task automatic dbg(input logic [7:0] c, input logic [31:0] a, input logic e);
    ctrl_wdata = c;
    pulse(0);
    pulse(3);
    i_vpt_host.access(a, 1'b0, 1'b0);
    check(dh, e);
    @(posedge clk);
    #1 check(stat[vpt_pkg::STAT_DBG_HIT], e);
  endtask : dbg
  // Holds chip reset for n edges; a request inside it must be ignored.
  task automatic creset(input int n);
    logic [31:0] keep;
    keep = fa;
    chip_rst = 1'b1;
    i_vpt_host.access(32'h0000_5000, 1'b0, 1'b0);
    check(pav_n, 1'b1);
    check(ra_n, 1'b0);
    repeat (n - 2) @(posedge clk);
    #1 chip_rst = 1'b0;
    repeat (2) @(posedge clk);
    #1 check(ctrl, vpt_pkg::CTRL_RESET);
    check(stat, n < vpt_pkg::RST_MIN_CYCLES ? 8'h08 : 8'h00);
    check(fa, keep);
    check(ra_n, 1'b1);
  endtask : creset
  // Main sequence.
  initial begin
    seed = 32'ha97e;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (POWERUP_CYCLES) @(posedge clk);
    #1 chip_rst = 1'b0;
    repeat (2) @(posedge clk);
    #1 check(stat, 8'h00);
    check(ra_n, 1'b1);
    for (k = 0; k < 8; k++) begin
      m_vp[k] = k * 17 + 1;
      m_fr[k] = $random(seed) & 32'hfffff;
      entry_idx = k[2:0];
      entry_wdata = {1'b1, k[0], k[1], m_vp[k][19:0], m_fr[k][19:0]};
      pulse(1);
    end
    probe(32'h0000_2abc, 1'b1, 1'b1);
    ctrl_wdata = 8'h01;
    pulse(0);
    xlat = 1'b1;
    for (i = 0; i < 48; i++) begin
      r = $random(seed);
      if (r[0])
        r[31:12] = m_vp[r[3:1]][19:0];
      probe(r, r[4], r[5]);
    end
    $display("translation test done");
    watch_lo = 32'h0000_5000;
    watch_hi = 32'h0000_5fff;
    pulse(2);
    dbg(8'h07, 32'h0000_5fff, 1'b1);
    dbg(8'h07, 32'h0000_6000, 1'b0);
    dbg(8'h03, 32'h0000_5000, 1'b1);
    dbg(8'h03, 32'h0000_5004, 1'b0);
    $display("watch test done");
    creset(64);
    creset(10);
    ctrl_wdata = 8'h01;
    pulse(0);
    probe({m_vp[2][19:0], 12'h123}, 1'b0, 1'b0);
    $display("reset test done");
    conclude();
  end
  // Cut a hang short; the power-up hold and the tests need about 5,300 cycles.
  initial begin
    #80000;
    bad_count++;
    conclude();
  end
endmodule : vpt_translator_tb

// ===== verilog/vpt_lookup.sv
// Fully associative page lookup producing hit, frame and permission result.
`timescale 1ns/100ps
module vpt_lookup (
  input  vpt_pkg::vpt_entry_s [vpt_pkg::TLB_ENTRIES-1:0] entries,
  input  wire logic [vpt_pkg::PAGE_W-1:0]                 vpage,
  input  wire logic                                       user_mode,
  input  wire logic                                       write_acc,
  output logic                                            hit,
  output logic                                            allowed,
  output logic [vpt_pkg::PAGE_W-1:0]                      frame
);
  logic [vpt_pkg::TLB_ENTRIES-1:0] match;
  logic [vpt_pkg::TLB_ENTRIES-1:0] perm;
  logic [vpt_pkg::PAGE_W-1:0]      fsel [vpt_pkg::TLB_ENTRIES];

  // Per-entry compare; a match with no rights still counts as resident.
  for (genvar i = 0; i < vpt_pkg::TLB_ENTRIES; i++) begin : g_ent
    assign match[i] = entries[i].valid && (entries[i].vpage == vpage);
    assign perm[i]  = (!user_mode || entries[i].user_ok) && (!write_acc || entries[i].write_ok);
    if (i == 0) begin : g_first
      assign fsel[i] = match[i] ? entries[i].frame : '0;
    end else begin : g_rest
      assign fsel[i] = match[i] ? entries[i].frame : fsel[i-1];
    end
  end

  // Access check is part of every translation.
  assign hit     = |match;
  assign allowed = |(match & perm);
  assign frame   = fsel[vpt_pkg::TLB_ENTRIES-1];
endmodule : vpt_lookup

// ===== verilog/vpt_pkg.sv
// Package with constants and carrier types for the virtual page translator.
package vpt_pkg;
  localparam int ADDR_W      = 32;
  localparam int PAGE_W      = 20;
  localparam int OFFS_W      = 12;
  localparam int PAGE_BYTES  = 4096;
  localparam int TLB_ENTRIES = 8;
  localparam int TLB_IDX_W   = 3;
  localparam int RST_MIN_CYCLES = 64;
  localparam int RST_CNT_W   = 7;
  localparam logic [RST_CNT_W-1:0] RST_CNT_MAX = 7'h7f;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int CTRL_XLAT_EN = 0;
  localparam int CTRL_DBG_EN  = 1;
  localparam int CTRL_DBG_RANGE = 2;
  localparam int STAT_FAULT   = 0;
  localparam int STAT_PROT    = 1;
  localparam int STAT_DBG_HIT = 2;
  localparam int STAT_SHORT_RST = 3;

  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [OFFS_W-1:0] offset;
  } vpt_vaddr_s;

  typedef struct packed {
    logic              valid;
    logic              user_ok;
    logic              write_ok;
    logic [PAGE_W-1:0] vpage;
    logic [PAGE_W-1:0] frame;
  } vpt_entry_s;

  typedef enum logic [1:0] {
    VPT_RESET  = 2'b00,
    VPT_IDLE   = 2'b01,
    VPT_ABORT  = 2'b11
  } vpt_state_e;
endpackage : vpt_pkg

// ===== verilog/vpt_translator.sv
// Top of the virtual page translator: translation, abort, fault capture, debug watch, reset.
`timescale 1ns/100ps
module vpt_translator (
  input  wire logic                          clock_phase_one,
  input  wire logic                          clock_phase_two,
  input  wire logic                          rst,
  input  wire logic                          chip_reset_input,
  input  wire logic                          addr_strobe,
  input  wire logic [vpt_pkg::ADDR_W-1:0]    virt_addr,
  input  wire logic                          user_mode,
  input  wire logic                          write_acc,
  input  wire logic                          ctrl_wr,
  input  wire logic [7:0]                    ctrl_wdata,
  input  wire logic                          entry_wr,
  input  wire logic [vpt_pkg::TLB_IDX_W-1:0] entry_idx,
  input  vpt_pkg::vpt_entry_s                entry_wdata,
  input  wire logic                          watch_wr,
  input  wire logic [vpt_pkg::ADDR_W-1:0]    watch_lo,
  input  wire logic [vpt_pkg::ADDR_W-1:0]    watch_hi,
  input  wire logic                          status_clr,
  output logic [vpt_pkg::ADDR_W-1:0]         phys_addr,
  output logic                               phys_addr_valid_strobe_n,
  output logic                               reset_abort_output_n,
  output logic [vpt_pkg::ADDR_W-1:0]         fault_addr,
  output logic [7:0]                         translation_control_reg,
  output logic [7:0]                         translation_status_reg,
  output logic                               debug_hit
);
  // The phase two clock is not needed: every register lives on phase one.
  // It stays on the port list because the clock source always delivers both phases,
  // and a later refinement of the output timing may want the second edge.
  logic                            in_reset_q;
  logic [vpt_pkg::RST_CNT_W-1:0]   rst_cnt_q;
  logic [vpt_pkg::RST_CNT_W-1:0]   rst_cnt_d;
  vpt_pkg::vpt_state_e             state_q;
  vpt_pkg::vpt_state_e             state_d;
  vpt_pkg::vpt_entry_s [vpt_pkg::TLB_ENTRIES-1:0] entries_q;
  logic [vpt_pkg::ADDR_W-1:0]      watch_lo_q;
  logic [vpt_pkg::ADDR_W-1:0]      watch_hi_q;
  logic [7:0]                      ctrl_q;
  logic [7:0]                      ctrl_d;
  logic [7:0]                      status_q;
  logic [7:0]                      status_d;
  logic [vpt_pkg::ADDR_W-1:0]      fault_q;
  logic [vpt_pkg::ADDR_W-1:0]      pa_q;
  logic                            pav_n_q;
  logic                            rab_n_q;
  logic                            dbg_q;

  vpt_pkg::vpt_vaddr_s             va;
  logic                            hit;
  logic                            allowed;
  logic [vpt_pkg::PAGE_W-1:0]      frame;
  logic                            xlat_en;
  logic                            go;
  logic                            do_abort;
  logic                            do_pass;
  logic                            watch_match;
  logic                            short_rst;
  logic                            entering_reset;
  // Next values of the output flops.
  logic [vpt_pkg::ADDR_W-1:0]      pa_d;
  logic                            pav_n_d;
  logic                            rab_n_d;
  logic                            dbg_d;

  // Address split: upper page number, lower byte offset within a 4 Kbyte page.
  assign va = virt_addr;

  vpt_lookup u_lookup (
    .entries   (entries_q),
    .vpage     (va.page),
    .user_mode (user_mode),
    .write_acc (write_acc),
    .hit       (hit),
    .allowed   (allowed),
    .frame     (frame)
  );

  // Request decode; with translation off pages map one to one and no check applies.
  assign xlat_en  = ctrl_q[vpt_pkg::CTRL_XLAT_EN];
  // A request on the very edge that first sees chip reset is refused as well.
  assign go       = addr_strobe && !chip_reset_input && !in_reset_q && (state_q == vpt_pkg::VPT_IDLE);
  assign do_abort = go && xlat_en && !(hit && allowed);
  assign do_pass  = go && !do_abort;

  // Debug watch, single address when range mode is off, else inclusive range.
  assign watch_match = ctrl_q[vpt_pkg::CTRL_DBG_RANGE] ?
                       ((virt_addr >= watch_lo_q) && (virt_addr <= watch_hi_q)) :
                       (virt_addr == watch_lo_q);

  // A reset release before the minimum hold count is flagged.
  assign entering_reset = chip_reset_input && !in_reset_q;
  assign short_rst = in_reset_q && !chip_reset_input &&
                     (rst_cnt_q < vpt_pkg::RST_CNT_W'(vpt_pkg::RST_MIN_CYCLES));

  // Reset hold counter saturates so a long reset never wraps back to short.
  assign rst_cnt_d = !chip_reset_input ? '0 :
                     (rst_cnt_q == vpt_pkg::RST_CNT_MAX) ? rst_cnt_q : rst_cnt_q + 1'b1;

  // Next state: the abort state lasts one cycle so the pulse is exactly one clock.
  always_comb begin
    state_d = state_q;
    case (state_q)
      vpt_pkg::VPT_RESET: begin
        if (!chip_reset_input) begin
          state_d = vpt_pkg::VPT_IDLE;
        end
      end
      vpt_pkg::VPT_IDLE: begin
        if (do_abort) begin
          state_d = vpt_pkg::VPT_ABORT;
        end
      end
      vpt_pkg::VPT_ABORT: begin
        state_d = vpt_pkg::VPT_IDLE;
      end
      default: begin
        state_d = vpt_pkg::VPT_IDLE;
      end
    endcase
    if (chip_reset_input) begin
      state_d = vpt_pkg::VPT_RESET;
    end
  end

  // Control is cleared by chip reset; software writes otherwise.
  assign ctrl_d = chip_reset_input ? vpt_pkg::CTRL_RESET :
                  ctrl_wr ? ctrl_wdata : ctrl_q;

  // Status: hardware set wins over a software clear arriving in the same cycle.
  always_comb begin
    status_d = status_clr ? vpt_pkg::STATUS_RESET : status_q;
    if (do_abort) begin
      status_d[vpt_pkg::STAT_FAULT] = 1'b1;
      status_d[vpt_pkg::STAT_PROT]  = hit;
    end
    if (go && ctrl_q[vpt_pkg::CTRL_DBG_EN] && watch_match) begin
      status_d[vpt_pkg::STAT_DBG_HIT] = 1'b1;
    end
    if (chip_reset_input) begin
      status_d = vpt_pkg::STATUS_RESET;
    end
    if (short_rst) begin
      status_d[vpt_pkg::STAT_SHORT_RST] = 1'b1;
    end
  end

  // Next values of the output stage; named wires keep every output flop to one assignment.
  assign pa_d    = !do_pass ? pa_q : (xlat_en ? {frame, va.offset} : virt_addr);
  assign pav_n_d = !(do_pass && !chip_reset_input);
  assign rab_n_d = !(chip_reset_input || (do_abort && !entering_reset));
  assign dbg_d   = go && ctrl_q[vpt_pkg::CTRL_DBG_EN] && watch_match;

  // Chip reset as seen on the last phase one edge; requests are refused while it is set.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      in_reset_q <= 1'b1;
    end else begin
      in_reset_q <= chip_reset_input;
    end
  end

  // Reset hold counter. Only its value on the release edge matters, so even a
  // glitch of a few cycles is counted and flagged rather than silently obeyed.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      rst_cnt_q <= '0;
    end else begin
      rst_cnt_q <= rst_cnt_d;
    end
  end

  // Timing state; it moves at most once per phase one edge.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      state_q <= vpt_pkg::VPT_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Control register, cleared by the power reset here and by chip reset through ctrl_d.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      ctrl_q <= vpt_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Status register. Its bits except the protection bit, which each abort rewrites, are sticky: once set they wait for a software clear or a chip reset,
  // so a handler that runs late still sees why the last access was stopped.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      status_q <= vpt_pkg::STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Translation entries are loaded from the side ports. Only the power reset clears them,
  // so a chip reset cannot throw away a table that software has already built.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      entries_q <= '0;
    end else if (entry_wr) begin
      entries_q[entry_idx] <= entry_wdata;
    end
  end

  // Lower watch bound, also the single watched address; kept through chip reset.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      watch_lo_q <= '0;
    end else if (watch_wr) begin
      watch_lo_q <= watch_lo;
    end
  end

  // Upper watch bound, only used in range mode; kept through chip reset.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      watch_hi_q <= '0;
    end else if (watch_wr) begin
      watch_hi_q <= watch_hi;
    end
  end

  // Fault address: written only by an abort and left alone by chip reset,
  // so the fault handler can read which page was missing.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      fault_q <= '0;
    end else if (do_abort) begin
      fault_q <= virt_addr;
    end
  end

  // Physical address holds the last translated address until the next pass.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      pa_q <= '0;
    end else begin
      pa_q <= pa_d;
    end
  end

  // Valid strobe, active low, one cycle per passed request.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      pav_n_q <= 1'b1;
    end else begin
      pav_n_q <= pav_n_d;
    end
  end

  // Reset/abort line: low through reset so it can reset the processor, and low for exactly
  // one cycle per abort; the abort state refuses the next request so no second pulse joins it.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      rab_n_q <= 1'b0;
    end else begin
      rab_n_q <= rab_n_d;
    end
  end

  // Debug hit pulse, one cycle for each taken request that falls on the watch.
  always_ff @(posedge clock_phase_one or posedge rst) begin
    if (rst) begin
      dbg_q <= 1'b0;
    end else begin
      dbg_q <= dbg_d;
    end
  end

  // Dedicated physical bus, separate from the virtual input.
  assign phys_addr                = pa_q;
  assign phys_addr_valid_strobe_n = pav_n_q;
  assign reset_abort_output_n     = rab_n_q;
  assign fault_addr               = fault_q;
  assign translation_control_reg  = ctrl_q;
  assign translation_status_reg   = status_q;
  assign debug_hit                = dbg_q;
endmodule : vpt_translator
